// >>> src/adcsr_pkg.sv
// Purpose: shared constants of the converter status, result and interrupt block
// Assumes: 32-bit register words on a byte-addressed bus
// Notes: offsets are byte addresses; status bit layout is shared by the mask registers
package adcsr_pkg;
  // geometry
  localparam int unsigned NCHAN = 8;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned DATA_W = 10;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned STAT_W = 20;

  // register offsets
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_LAST = 8'h20;
  localparam logic [7:0] OFF_IRQ_SET = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFF_IRQ_VIEW = 8'h2c;
  localparam logic [7:0] OFF_RESULT0 = 8'h30;
  localparam logic [7:0] OFF_RESULT7 = 8'h4c;

  // status field positions
  localparam int unsigned DONE_LSB = 0;
  localparam int unsigned OVR_LSB = 8;
  localparam int unsigned READY_BIT = 16;
  localparam int unsigned GOVR_BIT = 17;
  localparam int unsigned RXDONE_BIT = 18;
  localparam int unsigned RXEMPTY_BIT = 19;

  // values after reset
  localparam logic [31:0] STATUS_RST = 32'h000c0000;
  localparam logic [19:0] MASK_RST = 20'h00000;
  localparam logic [9:0] RESULT_RST = 10'h000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/adcsr_dma_watch.sv
// Purpose: watches the dma receive counters for the zero conditions
// Assumes: counters come from logic on the same clock
// Notes: the zero hit is a one-cycle pulse on the arrival at zero
`timescale 1ns/1ns
module adcsr_dma_watch #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CNT_W-1:0] dma_rx_counter,
  input wire logic [CNT_W-1:0] dma_rx_next_counter,
  output logic zero_hit,
  output logic both_zero
);
  typedef struct packed {
    logic was_zero;
  } adcsr_watch_s;

  adcsr_watch_s s_ff;
  adcsr_watch_s s_nxt;
  logic cnt_zero;

  // counter reaching zero, seen once per arrival
  assign cnt_zero = (dma_rx_counter == '0);
  assign zero_hit = cnt_zero && !s_ff.was_zero; // R5
  assign both_zero = cnt_zero && (dma_rx_next_counter == '0); // R6

  // remember the previous zero state
  always_comb begin
    s_nxt = s_ff;
    s_nxt.was_zero = cnt_zero;
  end

  // starts as zero so reset does not fake an arrival
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '{was_zero: 1'b1};
    end else begin
      s_ff <= s_nxt;
    end
  end
endmodule

// >>> src/adcsr_result_bank.sv
// Purpose: one result word per converter channel
// Assumes: conversion strobes come from the sequencer on the same clock
// Notes: a disabled channel keeps its old word
`timescale 1ns/1ns
module adcsr_result_bank #(
  parameter int unsigned NCHAN = 8,
  parameter int unsigned CHAN_W = 3,
  parameter int unsigned DATA_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NCHAN-1:0] chan_enable,
  input wire logic conv_done,
  input wire logic [CHAN_W-1:0] conv_chan,
  input wire logic [DATA_W-1:0] conv_data,
  output logic [NCHAN-1:0][DATA_W-1:0] results
);
  typedef struct packed {
    logic [NCHAN-1:0][DATA_W-1:0] res;
  } adcsr_bank_s;

  adcsr_bank_s s_ff;
  adcsr_bank_s s_nxt;
  logic [NCHAN-1:0] load;

  // per-channel load strobe, only for an enabled channel
  for (genvar i = 0; i < NCHAN; i++) begin : g_load
    assign load[i] = conv_done && (conv_chan == CHAN_W'(i)) && chan_enable[i]; // R8
  end

  // load or hold each word
  always_comb begin
    s_nxt = s_ff;
    for (int i = 0; i < NCHAN; i++) begin
      if (load[i]) begin
        s_nxt.res[i] = conv_data; // R8
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= s_nxt;
    end
  end

  assign results = s_ff.res;

  // disabling mid-conversion leaves the word undefined by contract, so no check on it
  AST_RESULT_LOAD: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (conv_done && chan_enable[conv_chan])
    |=> (s_ff.res[$past(conv_chan)] == $past(conv_data)))
    else $error("channel result not loaded");
endmodule

// >>> src/adcsr_top.sv
// Purpose: status, result and interrupt registers of an eight-channel converter
// Assumes: sequencer, channel enables and dma counters share aclk
// Notes: registers reached over axi4-lite, one write and one read in flight
//
// What this block does
// R1 - done bit reads 1 only for an enabled channel with a finished conversion
// R2 - channel overrun sticks until the status register is read
// R3 - ready bit sets on a new result, clears on reading the last result
// R4 - general overrun sticks until the status register is read
// R5 - receive done sets when the dma counter reaches zero, clears on counter writes
// R6 - receive empty reads 1 while both dma counters are zero
// R7 - last result captures every conversion, right aligned, held until the next
// R8 - channel result loads at its conversion only when the channel is enabled
// R9 - writing 1 to the enable-set register sets that mask bit
// R10 - writing 1 to the enable-clear register clears that mask bit
// R11 - mask view returns 1 for each enabled interrupt source
// R12 - software must not disable a channel during its conversion
// R13 - interrupt is high while any status bit and its mask bit are set
// R14 - reading a channel result clears that channel's done bit
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
module adcsr_top #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [adcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcsr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [adcsr_pkg::NCHAN-1:0] chan_enable,
  input wire logic conv_done,
  input wire logic [adcsr_pkg::CHAN_W-1:0] conv_chan,
  input wire logic [adcsr_pkg::DATA_W-1:0] conv_data,
  input wire logic [CNT_W-1:0] dma_rx_counter,
  input wire logic [CNT_W-1:0] dma_rx_next_counter,
  input wire logic dma_rx_counter_wr,
  input wire logic dma_rx_next_counter_wr,
  output logic irq
);
  typedef struct packed {
    logic aw_held;
    logic [adcsr_pkg::ADDR_W-1:0] aw_addr;
    logic awready;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_held;
    logic [adcsr_pkg::ADDR_W-1:0] ar_addr;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [adcsr_pkg::NCHAN-1:0] done;
    logic [adcsr_pkg::NCHAN-1:0] ovr;
    logic rdy;
    logic govr;
    logic rxdone;
    logic rxempty;
    logic [adcsr_pkg::STAT_W-1:0] mask;
    logic [adcsr_pkg::DATA_W-1:0] last;
    logic irq;
  } adcsr_state_s;

  localparam adcsr_state_s STATE_RST = '{
    aw_held: 1'b0, aw_addr: '0, awready: 1'b1,
    w_held: 1'b0, w_data: '0, w_strb: '0, wready: 1'b1,
    bvalid: 1'b0, bresp: adcsr_pkg::RESP_OKAY,
    ar_held: 1'b0, ar_addr: '0, arready: 1'b1,
    rvalid: 1'b0, rdata: '0, rresp: adcsr_pkg::RESP_OKAY,
    done: '0, ovr: '0, rdy: 1'b0, govr: 1'b0,
    rxdone: adcsr_pkg::STATUS_RST[adcsr_pkg::RXDONE_BIT],
    rxempty: adcsr_pkg::STATUS_RST[adcsr_pkg::RXEMPTY_BIT],
    mask: adcsr_pkg::MASK_RST, last: adcsr_pkg::RESULT_RST, irq: 1'b0
  };

  adcsr_state_s s_ff;
  adcsr_state_s s_nxt;

  logic [adcsr_pkg::NCHAN-1:0][adcsr_pkg::DATA_W-1:0] results;
  logic zero_hit;
  logic both_zero;
  logic wr_go;
  logic rd_go;
  logic [7:0] wr_word;
  logic [7:0] rd_word;
  logic wr_set;
  logic wr_clr;
  logic wr_ro;
  logic sel_stat;
  logic sel_last;
  logic sel_view;
  logic sel_res;
  logic [7:0] res_off;
  logic [adcsr_pkg::CHAN_W-1:0] res_idx;
  logic [31:0] wbits;
  logic [adcsr_pkg::STAT_W-1:0] stat_now;
  logic [adcsr_pkg::NCHAN-1:0] conv_hot;
  logic [adcsr_pkg::NCHAN-1:0] done_set;
  logic [adcsr_pkg::NCHAN-1:0] done_clr;
  logic stat_rd;
  logic irq_want;
  logic cnt_wr;
  logic [31:0] rd_val;
  logic rd_ok;

  // per-channel result words
  adcsr_result_bank #(
    .NCHAN(adcsr_pkg::NCHAN),
    .CHAN_W(adcsr_pkg::CHAN_W),
    .DATA_W(adcsr_pkg::DATA_W)
  ) adcsr_result_bank_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .chan_enable(chan_enable),
    .conv_done(conv_done),
    .conv_chan(conv_chan),
    .conv_data(conv_data),
    .results(results)
  );

  // dma counter zero detection
  adcsr_dma_watch #(
    .CNT_W(CNT_W)
  ) adcsr_dma_watch_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .dma_rx_counter(dma_rx_counter),
    .dma_rx_next_counter(dma_rx_next_counter),
    .zero_hit(zero_hit),
    .both_zero(both_zero)
  );

  // a write fires once both halves are held, a read once its address is held; low address bits ignored
  assign wr_go = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
  assign rd_go = s_ff.ar_held && !s_ff.rvalid;
  assign wr_word = {s_ff.aw_addr[7:2], 2'h0};
  assign rd_word = {s_ff.ar_addr[7:2], 2'h0};
  assign wr_set = (wr_word == adcsr_pkg::OFF_IRQ_SET);
  assign wr_clr = (wr_word == adcsr_pkg::OFF_IRQ_CLR);
  assign wr_ro = (wr_word >= adcsr_pkg::OFF_STATUS) && (wr_word <= adcsr_pkg::OFF_RESULT7);

  // read address decode
  assign sel_stat = (rd_word == adcsr_pkg::OFF_STATUS);
  assign sel_last = (rd_word == adcsr_pkg::OFF_LAST);
  assign sel_view = (rd_word == adcsr_pkg::OFF_IRQ_VIEW);
  assign sel_res = (rd_word >= adcsr_pkg::OFF_RESULT0) && (rd_word <= adcsr_pkg::OFF_RESULT7);
  assign res_off = rd_word - adcsr_pkg::OFF_RESULT0;
  assign res_idx = res_off[adcsr_pkg::CHAN_W+1:2];
  assign stat_rd = rd_go && sel_stat; // the status read that clears overruns
  assign cnt_wr = dma_rx_counter_wr || dma_rx_next_counter_wr;

  // byte lanes gate the written bits
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wbits[8*b +: 8] = s_ff.w_strb[b] ? s_ff.w_data[8*b +: 8] : 8'h00;
    end
  end

  // status as software sees it; a disabled channel never shows done
  always_comb begin
    stat_now = '0;
    stat_now[adcsr_pkg::DONE_LSB +: adcsr_pkg::NCHAN] = s_ff.done & chan_enable; // R1
    stat_now[adcsr_pkg::OVR_LSB +: adcsr_pkg::NCHAN] = s_ff.ovr;
    stat_now[adcsr_pkg::READY_BIT] = s_ff.rdy;
    stat_now[adcsr_pkg::GOVR_BIT] = s_ff.govr;
    stat_now[adcsr_pkg::RXDONE_BIT] = s_ff.rxdone;
    stat_now[adcsr_pkg::RXEMPTY_BIT] = s_ff.rxempty;
    irq_want = |(stat_now & s_ff.mask); // R13
  end

  // conversion events decoded per channel
  always_comb begin
    conv_hot = '0;
    conv_hot[conv_chan] = conv_done;
    done_set = conv_hot & chan_enable; // R1
    done_clr = '0;
    done_clr[res_idx] = rd_go && sel_res; // R14
  end

  // read data mux; unmapped words answer slverr with zero data
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (sel_stat) begin
      rd_val = 32'(stat_now);
    end else if (sel_last) begin
      rd_val = 32'(s_ff.last); // R7
    end else if (sel_view) begin
      rd_val = 32'(s_ff.mask); // R11
    end else if (sel_res) begin
      rd_val = 32'(results[res_idx]);
    end else begin
      rd_ok = 1'b0;
    end
  end

  // next state: bus handshakes, then flags; a set always beats a same-cycle clear
  always_comb begin
    s_nxt = s_ff;
    if (s_axi_awvalid && s_ff.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (wr_ro || wr_set || wr_clr) ? adcsr_pkg::RESP_OKAY
                                                 : adcsr_pkg::RESP_SLVERR;
      if (wr_set) begin
        s_nxt.mask = s_ff.mask | wbits[adcsr_pkg::STAT_W-1:0]; // R9
      end
      if (wr_clr) begin
        s_nxt.mask = s_ff.mask & ~wbits[adcsr_pkg::STAT_W-1:0]; // R10
      end
    end
    // readies return only once the response is gone, keeping one write in flight
    if (s_ff.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      s_nxt.ar_held = 1'b1;
      s_nxt.ar_addr = s_axi_araddr;
      s_nxt.arready = 1'b0;
    end
    if (rd_go) begin
      s_nxt.ar_held = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_val;
      s_nxt.rresp = rd_ok ? adcsr_pkg::RESP_OKAY : adcsr_pkg::RESP_SLVERR;
    end
    if (s_ff.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    // converter flags
    s_nxt.done = (s_ff.done & ~done_clr) | done_set; // R14
    s_nxt.ovr = (s_ff.ovr & ~{adcsr_pkg::NCHAN{stat_rd}})
              | (done_set & s_ff.done); // R2
    s_nxt.rdy = (s_ff.rdy && !(rd_go && sel_last)) || conv_done; // R3
    s_nxt.govr = (s_ff.govr && !stat_rd) || (conv_done && s_ff.rdy); // R4
    if (conv_done) begin
      s_nxt.last = conv_data; // R7
    end
    s_nxt.rxdone = (s_ff.rxdone && !cnt_wr) || zero_hit; // R5
    s_nxt.rxempty = both_zero; // R6
    // one cycle behind the flags, trading latency for a clean registered pin
    s_nxt.irq = irq_want; // R13
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= STATE_RST;
    end else begin
      s_ff <= s_nxt;
    end
  end

  // every output straight from the state register
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign irq = s_ff.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // single-cycle sequences
  sequence set_write;
    wr_go && wr_set;
  endsequence
  sequence clr_write;
    wr_go && wr_clr;
  endsequence
  sequence both_taken;
    s_axi_awvalid && s_ff.awready && s_axi_wvalid && s_ff.wready;
  endsequence

  AST_DONE_HIDDEN: assert property (stat_rd |=> // R1
    ((s_axi_rdata[7:0] & ~$past(chan_enable)) == 8'h00))
    else $error("done bit shown for a disabled channel");
  AST_OVR_STICKY: assert property (!stat_rd |=> // R2
    ((s_ff.ovr & $past(s_ff.ovr)) == $past(s_ff.ovr)))
    else $error("channel overrun dropped without a status read");
  AST_OVR_CLEAR: assert property ((stat_rd && !conv_done) |=> (s_ff.ovr == '0)) // R2
    else $error("channel overrun not cleared by status read");
  AST_READY_SET: assert property (conv_done |=> s_ff.rdy) // R3
    else $error("ready bit not set by a conversion");
  AST_READY_CLEAR: assert property ((rd_go && sel_last && !conv_done) |=> !s_ff.rdy) // R3
    else $error("ready bit not cleared by last result read");
  // a status read in the second cycle may clear it, nothing else may
  AST_GOVR_SET: assert property ((conv_done && s_ff.rdy) |=> // R4
    s_ff.govr ##1 (s_ff.govr || $past(stat_rd)))
    else $error("general overrun not held");
  AST_RXDONE: assert property (zero_hit |=> s_ff.rxdone) // R5
    else $error("receive done not set at counter zero");
  AST_RXDONE_CLR: assert property ((cnt_wr && !zero_hit) |=> !s_ff.rxdone) // R5
    else $error("receive done not cleared by counter write");
  AST_RXEMPTY: assert property (1'b1 |=> (s_ff.rxempty == $past(both_zero))) // R6
    else $error("receive empty does not follow the counters");
  AST_LAST_CAPTURE: assert property (conv_done |=> // R7
    (s_ff.last == $past(conv_data)) ##1 ($past(conv_done) || $stable(s_ff.last)))
    else $error("last result not captured or not held");
  AST_MASK_SET: assert property (set_write |=> // R9
    ((s_ff.mask & $past(wbits[19:0])) == $past(wbits[19:0])))
    else $error("enable-set write did not set mask bits");
  AST_MASK_CLR: assert property (clr_write |=> ((s_ff.mask & $past(wbits[19:0])) == '0)) // R10
    else $error("enable-clear write did not clear mask bits");
  AST_MASK_VIEW: assert property ((rd_go && sel_view) |=> // R11
    (s_axi_rdata == 32'($past(s_ff.mask))))
    else $error("mask view mismatch");
  AST_IRQ_LEVEL: assert property (1'b1 |=> (irq == $past(irq_want))) // R13
    else $error("interrupt level mismatch");
  AST_DONE_CLR: assert property ((rd_go && sel_res && !conv_done) |=> // R14
    !s_ff.done[$past(res_idx)])
    else $error("done bit not cleared by result read");
  AST_WRITE_ANSWER: assert property (both_taken |-> ##[2:2] s_axi_bvalid)
    else $error("write response late");
endmodule

// >>> bench/adcsr_partner.sv
// Purpose: sequencer and dma counter stand-in facing the converter block
// Assumes: tasks are called just after a rising edge of aclk
// Notes: idle data toggles each cycle so a stale value never looks valid
`timescale 1ns/1ns
module adcsr_partner (
  input wire logic aclk,
  output logic [7:0] chan_enable,
  output logic conv_done,
  output logic [2:0] conv_chan,
  output logic [9:0] conv_data,
  output logic [15:0] dma_rx_counter,
  output logic [15:0] dma_rx_next_counter,
  output logic dma_rx_counter_wr,
  output logic dma_rx_next_counter_wr
);
  logic go = 1'b0;
  logic is_cnv = 1'b0;
  logic [2:0] st_ch = 3'h0;
  logic [9:0] st_d = 10'h000;
  logic [15:0] st_c = 16'h0000;
  logic [15:0] st_n = 16'h0000;
  logic [1:0] st_w = 2'h0;
  initial begin
    chan_enable = 8'h00;
    conv_done = 1'b0;
    conv_chan = 3'h0;
    conv_data = 10'h155;
    dma_rx_counter = 16'h0000;
    dma_rx_next_counter = 16'h0000;
    dma_rx_counter_wr = 1'b0;
    dma_rx_next_counter_wr = 1'b0;
  end
  // one edge carries a whole request, so nothing is assigned twice per step
  always @(posedge aclk) begin
    conv_done <= go & is_cnv;
    conv_data <= (go & is_cnv) ? st_d : ~conv_data;
    dma_rx_counter_wr <= go & ~is_cnv & st_w[0];
    dma_rx_next_counter_wr <= go & ~is_cnv & st_w[1];
    if (go & is_cnv) begin
      conv_chan <= st_ch;
    end
    if (go & ~is_cnv) begin
      dma_rx_counter <= st_c;
      dma_rx_next_counter <= st_n;
    end
    go <= 1'b0;
  end
  // slow adds idle cycles before the pulse
  task automatic convert(input logic [2:0] ch, input logic [9:0] d, input int slow);
    st_ch = ch;
    st_d = d;
    is_cnv = 1'b1;
    repeat (slow) @(posedge aclk);
    #1 go = 1'b1;
    wait (go == 1'b0);
  endtask
  task automatic set_counts(input logic [15:0] c, input logic [15:0] n, input logic [1:0] w);
    st_c = c;
    st_n = n;
    st_w = w;
    is_cnv = 1'b0;
    #1 go = 1'b1;
    wait (go == 1'b0);
  endtask
  // only called between conversions, never while one runs
  task automatic set_enable(input logic [7:0] e);
    chan_enable <= e;
  endtask
endmodule

// >>> bench/adc_status_result_interrupt_bench.sv
// Purpose: self-checking bench of the converter status and interrupt block
// Assumes: answers are compared from queues by a watching process
// Notes: a model of the flags tracks every conversion, read and counter write
`timescale 1ns/1ns
module adc_status_result_interrupt_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  // answer readies stay up, so no strobe is lowered and raised in one step
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  wire awready, wready, bvalid, arready, rvalid, irq, conv_done, c_wr, n_wr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] chan_en;
  wire [2:0] conv_chan;
  wire [9:0] conv_data;
  wire [15:0] c_cnt, n_cnt;
  int n_mismatch = 0, tests_run = 0, cyc = 0, seed = 65, i;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] done = 8'h0, ovr = 8'h0, en = 8'h0;
  logic rdy = 1'b0, govr = 1'b0, rxd = 1'b1, rxe = 1'b1;
  logic [9:0] last = 10'h0;
  logic [9:0] res[8];
  logic [19:0] mask = 20'h0;
  logic [15:0] prev_c = 16'h0;
  logic [31:0] rv, wv;
  localparam logic [1:0] OK = adcsr_pkg::RESP_OKAY;

  always #10 aclk = ~aclk;

  adcsr_top adcsr_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_enable(chan_en), .conv_done(conv_done), .conv_chan(conv_chan),
    .conv_data(conv_data), .dma_rx_counter(c_cnt), .dma_rx_next_counter(n_cnt),
    .dma_rx_counter_wr(c_wr), .dma_rx_next_counter_wr(n_wr), .irq(irq));

  adcsr_partner adcsr_partner_inst (.aclk(aclk), .chan_enable(chan_en), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_data(conv_data), .dma_rx_counter(c_cnt),
    .dma_rx_next_counter(n_cnt), .dma_rx_counter_wr(c_wr), .dma_rx_next_counter_wr(n_wr));

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // answers are taken off the queues at their handshake edge; hang guard
  always @(posedge aclk) begin
    cyc++;
    if (rvalid && rready) begin
      cmp("rdata", rq[0][31:0], rdata);
      cmp("rresp", {30'h0, rq[0][33:32]}, {30'h0, rresp});
      void'(rq.pop_front());
    end
    if (bvalid && bready) begin
      cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
    end
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    rq.push_back({r, e});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask

  // model reads: status clears overruns, last clears ready, result clears done
  task automatic rd_stat();
    axi_rd(adcsr_pkg::OFF_STATUS, {12'h0, rxe, rxd, govr, rdy, ovr, done & en}, OK);
    ovr = 8'h0;
    govr = 1'b0;
  endtask
  task automatic rd_last();
    axi_rd(adcsr_pkg::OFF_LAST, {22'h0, last}, OK);
    rdy = 1'b0;
  endtask
  task automatic rd_res(input int n);
    axi_rd(8'(adcsr_pkg::OFF_RESULT0 + 4 * n), {22'h0, res[n]}, OK);
    done[n] = 1'b0;
  endtask
  task automatic conv(input logic [2:0] ch, input int slow);
    rv = $random(seed);
    adcsr_partner_inst.convert(ch, rv[9:0], slow);
    if (done[ch] && en[ch]) ovr[ch] = 1'b1;
    govr = govr | rdy;
    rdy = 1'b1;
    last = rv[9:0];
    if (en[ch]) begin
      done[ch] = 1'b1;
      res[ch] = rv[9:0];
    end
  endtask
  // a write pulse clears receive done unless the counter just hit zero
  task automatic dma(input logic [15:0] c, input logic [15:0] n, input logic [1:0] w);
    adcsr_partner_inst.set_counts(c, n, w);
    if (w != 2'b00) rxd = 1'b0;
    if (c == 16'h0 && prev_c != 16'h0) rxd = 1'b1;
    rxe = (c == 16'h0 && n == 16'h0);
    prev_c = c;
    repeat (3) @(posedge aclk);
  endtask
  task automatic chk_irq();
    repeat (2) @(posedge aclk);
    cmp("irq", {31'h0, |({rxe, rxd, govr, rdy, ovr, done & en} & mask)}, {31'h0, irq});
  endtask

  // main sequence
  initial begin
    foreach (res[k]) res[k] = 10'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_stat();
    rd_last();
    axi_rd(adcsr_pkg::OFF_IRQ_VIEW, 32'h0, OK);
    for (i = 0; i < 8; i++) rd_res(i);
    axi_rd(8'h50, 32'h0, adcsr_pkg::RESP_SLVERR);
    axi_wr(8'h00, 32'hffffffff, adcsr_pkg::RESP_SLVERR);
    axi_wr(adcsr_pkg::OFF_STATUS, 32'hffffffff, OK);
    // half the channels enabled, back to back and slow pulses
    adcsr_partner_inst.set_enable(8'h0f);
    en = 8'h0f;
    for (i = 0; i < 8; i++) conv(3'(i), i % 3);
    rd_stat();
    rd_last();
    rd_stat();
    for (i = 0; i < 8; i++) rd_res(i);
    rd_stat();
    conv(3'h2, 0);
    conv(3'h2, 1);
    rd_stat();
    rd_stat();
    // done reads as gated by the live enable
    conv(3'h1, 0);
    @(posedge aclk); // the pulse is sampled before the enable moves
    adcsr_partner_inst.set_enable(8'h0d);
    en = 8'h0d;
    rd_stat();
    adcsr_partner_inst.set_enable(8'h0f);
    en = 8'h0f;
    rd_stat();
    dma(16'h0003, 16'h0002, 2'b01);
    rd_stat();
    dma(16'h0000, 16'h0002, 2'b00);
    rd_stat();
    dma(16'h0000, 16'h0000, 2'b10);
    rd_stat();
    for (i = 0; i < 6; i++) begin
      rv = $random(seed);
      wv = $random(seed);
      // random byte lanes on the set write, full lanes on the clear
      wstrb <= wv[31:28];
      axi_wr(adcsr_pkg::OFF_IRQ_SET, rv, OK);
      mask = mask | (rv[19:0] & {{4{wv[30]}}, {8{wv[29]}}, {8{wv[28]}}});
      wstrb <= 4'hf;
      axi_wr(adcsr_pkg::OFF_IRQ_CLR, wv, OK);
      mask = mask & ~wv[19:0];
      axi_rd(adcsr_pkg::OFF_IRQ_VIEW, {12'h0, mask}, OK);
      chk_irq();
    end
    axi_wr(adcsr_pkg::OFF_IRQ_CLR, 32'hffffffff, OK);
    mask = 20'h0;
    conv(3'h0, 0);
    chk_irq();
    axi_wr(adcsr_pkg::OFF_IRQ_SET, 32'h00010000, OK);
    mask = 20'h10000;
    chk_irq();
    rd_last();
    chk_irq();
    @(posedge aclk);
    tally_and_finish();
  end
endmodule
